// ---- hdl/arm_regs.sv ----
`timescale 1ns/1ps
// Contract
// R1: A 3-bit target field picks the port measured by the rate calculator.
// R2: Result register has busy flag on top and an echo of the measured port.
// R3: Port rate is a 4-bit code, zero meaning out of range.
// R4: Status reads are live, and no read clears anything.
// R5: With no source on the target, stay busy and keep the old rate code.
// R6: Calculator and stream status work only while the receiver is powered.
// R7: Stream busy flag high while calculating or unlocked; rate code then holds.
// R8: Stream rate uses the same 4-bit table as the port calculator.
// R9: A status bit mirrors channel status bit 1, the non-audio flag.
// R10: Burst type word is captured across two read-only bytes.
// R11: Host reads burst words only after a detection flag goes high.
// R12: Burst length updates with the type word; an update flag tells the host.
// R13: Writing 0 to mode reset restores control defaults, then bit returns to 1.
// R14: Writing 0 to converter reset resets the converter; bit self-restores.
// R15: Four power-down bits, active high, all reset to 0.
// R16: Host keeps the converter system clock running when powering it down.
// R17: Oscillator power-down wins over automatic oscillator control.
// R18: Clock-output control keeps converter clocks driven in power-down when 0.
// R19: Data select routes internal or external converter data to main output.
// R20: Limiter with receiver clock source and lock in 14-111 kHz forces power-down.
// R21: A 3-bit field selects the converter clock source, default crystal.
// R22: Host normally picks the crystal divider as converter clock source.
// R23: Reserved bits read zero; read-only registers ignore writes.
module arm_regs (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    input  wire logic       portCalcBusy,
    input  wire logic [3:0] portCalcRate,
    input  wire logic       streamCalcBusy,
    input  wire logic       streamLocked,
    input  wire logic [3:0] streamRate,
    input  wire logic       channelStatusBit1,
    input  wire logic       burstValid,
    input  wire logic [15:0] burstTypeIn,
    input  wire logic [15:0] burstLengthIn,
    input  wire logic       oscillatorAutoRequest,
    input  wire logic       internalConverterData,
    input  wire logic       externalConverterData,
    output logic      [2:0] rateTargetSelect,
    output logic            burstUpdatePulse,
    output logic            controlDefaultPulse,
    output logic            converterResetPulse,
    output logic            converterPowerDown,
    output logic            receiverPowerDown,
    output logic            transmitterPowerDown,
    output logic            oscillatorRun,
    output logic            converterClockOutEnable,
    output logic            mainDataOut,
    output logic      [2:0] converterClockSource
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic       extData;
    logic       cs1;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA <= 2'h0;
            syncB <= 2'h0;
        end else begin
            syncA <= {syncA[0], externalConverterData};
            syncB <= {syncB[0], channelStatusBit1};
        end
    end
    assign extData = syncA[1];
    assign cs1     = syncB[1];

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] target;
    logic [7:0] sysCtl;
    logic [7:0] convCtl;
    logic [15:0] burstType;
    logic [15:0] burstLength;
    logic       nonAudio;
    logic [7:0] next_target;
    logic [7:0] next_sysCtl;
    logic [7:0] next_convCtl;
    logic [15:0] next_burstType;
    logic [15:0] next_burstLength;
    logic       next_nonAudio;
    logic       next_burstUpdatePulse;
    logic       next_controlDefaultPulse;
    logic       next_converterResetPulse;
    logic       wrSys;
    logic       modeResetReq;
    logic       rxOn;

    assign wrSys        = regWrEn && (regAddr == arm_pkg::SYSTEM_RESET_POWER_CONTROL);
    assign modeResetReq = wrSys && !regWrData[arm_pkg::BIT_MODE_REGISTER_RESET];
    assign rxOn         = !sysCtl[arm_pkg::BIT_RX_PD];

    always_comb begin
        next_target  = target;
        next_sysCtl  = sysCtl;
        next_convCtl = convCtl;
        if (regWrEn && regAddr == arm_pkg::RATE_CALC_TARGET_SELECT) begin
            next_target = regWrData & arm_pkg::TARGET_MASK; // R1 R23
        end
        if (regWrEn && regAddr == arm_pkg::CONVERTER_CONTROL_ONE) begin
            next_convCtl = regWrData & arm_pkg::CONVCTL_MASK; // R21 R23
        end
        if (wrSys) begin
            next_sysCtl = regWrData & arm_pkg::SYSCTL_MASK; // R15
        end
        // Both reset bits always come back as 1 one cycle after the write.
        next_sysCtl[arm_pkg::BIT_MODE_REGISTER_RESET] = 1'b1; // R13 R14
        next_sysCtl[arm_pkg::BIT_CONVERTER_RESET] = 1'b1; // R14
        if (modeResetReq) begin
            next_target  = arm_pkg::TARGET_RESET; // R13
            next_convCtl = arm_pkg::CONVCTL_RESET;
            next_sysCtl  = arm_pkg::SYSCTL_RESET;
        end
        next_controlDefaultPulse = modeResetReq; // R13
        next_converterResetPulse = wrSys && !regWrData[arm_pkg::BIT_CONVERTER_RESET]; // R14
    end

    // Stream status is captured only while the receiver is powered.
    always_comb begin
        next_burstType        = burstType;
        next_burstLength      = burstLength;
        next_nonAudio         = nonAudio;
        next_burstUpdatePulse = 1'b0;
        if (rxOn) begin
            next_nonAudio = cs1; // R9 R6
            if (burstValid) begin
                next_burstType        = burstTypeIn; // R10
                next_burstLength      = burstLengthIn; // R12
                next_burstUpdatePulse = burstTypeIn != burstType; // R12
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            target              <= arm_pkg::TARGET_RESET;
            sysCtl              <= arm_pkg::SYSCTL_RESET;
            convCtl             <= arm_pkg::CONVCTL_RESET;
            burstType           <= 16'h0000;
            burstLength         <= 16'h0000;
            nonAudio            <= 1'b0;
            burstUpdatePulse    <= 1'b0;
            controlDefaultPulse <= 1'b0;
            converterResetPulse <= 1'b0;
        end else begin
            target              <= next_target;
            sysCtl              <= next_sysCtl;
            convCtl             <= next_convCtl;
            burstType           <= next_burstType;
            burstLength         <= next_burstLength;
            nonAudio            <= next_nonAudio;
            burstUpdatePulse    <= next_burstUpdatePulse;
            controlDefaultPulse <= next_controlDefaultPulse;
            converterResetPulse <= next_converterResetPulse;
        end
    end

    // ------------------------------------------------------------------
    // Rate holders
    // ------------------------------------------------------------------
    logic       portBusy;
    logic [3:0] portRate;
    logic       streamBusy;
    logic [3:0] streamRateHeld;
    logic [2:0] echo;
    logic [2:0] next_echo;

    // A powered-down receiver keeps both calculators busy and frozen.
    arm_rate_hold portHold (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .busyIn  (portCalcBusy || !rxOn), // R5 R6
        .rateIn  (portCalcRate), // R3
        .busy    (portBusy),
        .rate    (portRate)
    );

    arm_rate_hold streamHold (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .busyIn  (streamCalcBusy || !streamLocked || !rxOn), // R7 R6
        .rateIn  (streamRate), // R8
        .busy    (streamBusy),
        .rate    (streamRateHeld)
    );

    always_comb begin
        next_echo = portBusy ? echo : target[2:0]; // R2
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo <= 3'h0;
        end else begin
            echo <= next_echo;
        end
    end

    // ------------------------------------------------------------------
    // Read path and outputs
    // ------------------------------------------------------------------
    logic [7:0] next_regRdData;
    logic       limiterForce;
    logic       adcDown;
    logic       next_mainData;
    logic       next_oscillatorRun;
    logic       next_converterClockOutEnable;

    // Reads have no side effect on any state.
    always_comb begin
        next_regRdData = regRdData;
        if (regRdEn) begin
            case (regAddr) // R4 R23
                arm_pkg::RATE_CALC_TARGET_SELECT:     next_regRdData = target;
                arm_pkg::RATE_CALC_RESULT:            next_regRdData = {portBusy, echo, portRate};
                arm_pkg::INCOMING_STREAM_RATE_STATUS: next_regRdData = {streamBusy, nonAudio,
                                                                        2'h0, streamRateHeld};
                arm_pkg::BURST_TYPE_LOW:              next_regRdData = burstType[7:0];
                arm_pkg::BURST_TYPE_HIGH:             next_regRdData = burstType[15:8];
                arm_pkg::BURST_LENGTH_LOW:            next_regRdData = burstLength[7:0];
                arm_pkg::BURST_LENGTH_HIGH:           next_regRdData = burstLength[15:8];
                arm_pkg::SYSTEM_RESET_POWER_CONTROL:  next_regRdData = sysCtl;
                arm_pkg::CONVERTER_CONTROL_ONE:       next_regRdData = convCtl;
                default:                              next_regRdData = 8'h00;
            endcase
        end
    end

    // The limiter window 14 to 111 kHz covers the codes 16 kHz to 96 kHz.
    assign limiterForce = convCtl[arm_pkg::BIT_LIMITER]
                       && convCtl[2:0] == arm_pkg::CLK_SRC_RECEIVER
                       && streamLocked && rxOn
                       && streamRate >= arm_pkg::RATE_16K
                       && streamRate <= arm_pkg::RATE_96K; // R20
    assign adcDown = sysCtl[arm_pkg::BIT_ADC_PD] || limiterForce;
    assign next_mainData = convCtl[arm_pkg::BIT_DATA_SEL] ? extData
                                                          : internalConverterData; // R19
    assign next_oscillatorRun = !sysCtl[arm_pkg::BIT_OSC_PD] && oscillatorAutoRequest; // R17
    assign next_converterClockOutEnable = !(adcDown && convCtl[arm_pkg::BIT_CLK_OUT]); // R18

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData               <= 8'h00;
            converterPowerDown      <= 1'b0;
            receiverPowerDown       <= 1'b0;
            transmitterPowerDown    <= 1'b0;
            oscillatorRun           <= 1'b0;
            converterClockOutEnable <= 1'b1;
            mainDataOut             <= 1'b0;
            rateTargetSelect        <= arm_pkg::TARGET_RESET[2:0];
            converterClockSource    <= arm_pkg::CONVCTL_RESET[2:0];
        end else begin
            regRdData               <= next_regRdData;
            converterPowerDown      <= adcDown; // R15 R20
            receiverPowerDown       <= sysCtl[arm_pkg::BIT_RX_PD];
            transmitterPowerDown    <= sysCtl[arm_pkg::BIT_TX_PD];
            oscillatorRun           <= next_oscillatorRun; // R17
            converterClockOutEnable <= next_converterClockOutEnable; // R18
            mainDataOut             <= next_mainData;
            rateTargetSelect        <= target[2:0];
            converterClockSource    <= convCtl[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    mode_reset_restore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        modeResetReq |=> (target == arm_pkg::TARGET_RESET && convCtl == arm_pkg::CONVCTL_RESET))
        else $error("mode reset did not restore defaults"); // R13
    reset_bits_restore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrSys |=> (sysCtl[7:6] == 2'b11)) else $error("reset bits not restored"); // R14
    conv_reset_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wrSys && !regWrData[arm_pkg::BIT_CONVERTER_RESET]) |=> converterResetPulse)
        else $error("converter reset pulse missing"); // R14
    osc_pd_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sysCtl[arm_pkg::BIT_OSC_PD] |=> !oscillatorRun) else $error("oscillator ran"); // R17
    limiter_force_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        limiterForce |=> converterPowerDown) else $error("limiter did not power down"); // R20
    clock_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (adcDown && !convCtl[arm_pkg::BIT_CLK_OUT]) |=> converterClockOutEnable)
        else $error("clock outputs dropped"); // R18
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (regRdEn && regAddr == arm_pkg::RATE_CALC_TARGET_SELECT) |=> regRdData[7:3] == 5'h00)
        else $error("reserved bits not zero"); // R23
    rx_off_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!rxOn && $past(!rxOn)) |=> $stable(portRate) && $stable(nonAudio))
        else $error("status moved while receiver down"); // R6
    burst_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $changed(burstLength) |-> $past(burstValid)) else $error("length moved alone"); // R12
    data_route_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !convCtl[arm_pkg::BIT_DATA_SEL] |=> mainDataOut == $past(internalConverterData))
        else $error("main data misrouted"); // R19
endmodule : arm_regs

// ---- hdl/arm_pkg.sv ----
package arm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RATE_CALC_TARGET_SELECT     = 8'h37;
    localparam logic [7:0] RATE_CALC_RESULT            = 8'h38;
    localparam logic [7:0] INCOMING_STREAM_RATE_STATUS = 8'h39;
    localparam logic [7:0] BURST_TYPE_LOW              = 8'h3a;
    localparam logic [7:0] BURST_TYPE_HIGH             = 8'h3b;
    localparam logic [7:0] BURST_LENGTH_LOW            = 8'h3c;
    localparam logic [7:0] BURST_LENGTH_HIGH           = 8'h3d;
    localparam logic [7:0] SYSTEM_RESET_POWER_CONTROL  = 8'h40;
    localparam logic [7:0] CONVERTER_CONTROL_ONE       = 8'h42;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] TARGET_RESET   = 8'h00;
    localparam logic [7:0] SYSCTL_RESET   = 8'hc0;
    localparam logic [7:0] CONVCTL_RESET  = 8'h02;
    localparam logic [7:0] TARGET_MASK    = 8'h07;
    localparam logic [7:0] SYSCTL_MASK    = 8'hf3;
    localparam logic [7:0] CONVCTL_MASK   = 8'h3f;
    localparam int         BIT_MODE_REGISTER_RESET       = 7;
    localparam int         BIT_CONVERTER_RESET       = 6;
    localparam int         BIT_ADC_PD     = 5;
    localparam int         BIT_RX_PD      = 4;
    localparam int         BIT_TX_PD      = 1;
    localparam int         BIT_OSC_PD     = 0;
    localparam int         BIT_CLK_OUT    = 5;
    localparam int         BIT_DATA_SEL   = 4;
    localparam int         BIT_LIMITER    = 3;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CLK_SRC_RECEIVER = 3'h1;
    localparam logic [3:0] RATE_16K         = 4'h4;
    localparam logic [3:0] RATE_96K         = 4'hc;
    localparam logic [3:0] RATE_OUT_RANGE   = 4'h0;

endpackage : arm_pkg

// ---- hdl/arm_rate_hold.sv ----
`timescale 1ns/1ps
// Holds a rate code while a measurement is busy and loads it when done.
module arm_rate_hold (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       busyIn,
    input  wire logic [3:0] rateIn,
    output logic            busy,
    output logic      [3:0] rate
);
    logic       next_busy;
    logic [3:0] next_rate;

    always_comb begin
        next_busy = busyIn;
        next_rate = busyIn ? rate : rateIn;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b1;
            rate <= arm_pkg::RATE_OUT_RANGE;
        end else begin
            busy <= next_busy;
            rate <= next_rate;
        end
    end

    busy_holds_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        busyIn |=> $stable(rate)) else $error("rate changed while busy");
endmodule : arm_rate_hold

// ---- dv/arm_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Host on the byte register port
// ----------------------------------------------------------------------
// Every request waits for an edge first, so two strobes never touch in one time step.
module arm_host_model (
    input  wire logic       ref_clk,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrEn,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData
);
    initial begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrEn   = 1'b0;
        regWrData = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        @(posedge ref_clk);
        #1;
        d = regRdData;
    endtask : rd
endmodule : arm_host_model

// ---- dv/audio_rate_monitor_and_power_control_tb.sv ----
`timescale 1ns/1ps
module audio_rate_monitor_and_power_control_tb;
    logic        ref_clk, rst_b, regWrEn, regRdEn, portCalcBusy, streamCalcBusy;
    logic        streamLocked, channelStatusBit1, burstValid, oscillatorAutoRequest;
    logic        internalConverterData, externalConverterData, burstUpdatePulse;
    logic        controlDefaultPulse, converterResetPulse, converterPowerDown;
    logic        receiverPowerDown, transmitterPowerDown, oscillatorRun;
    logic        converterClockOutEnable, mainDataOut;
    logic [7:0]  regAddr, regWrData, regRdData, d;
    logic [3:0]  portCalcRate, streamRate;
    logic [15:0] burstTypeIn, burstLengthIn;
    logic [2:0]  rateTargetSelect, converterClockSource;
    int          fail_count = 0;
    int          checks = 0;
    int          updCnt = 0;
    int          defCnt = 0;
    int          rstCnt = 0;
    int unsigned seed = 23;
    int          lim[4] = '{3, 4, 12, 13};

    arm_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

    arm_regs u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .portCalcBusy(portCalcBusy), .portCalcRate(portCalcRate),
        .streamCalcBusy(streamCalcBusy), .streamLocked(streamLocked), .streamRate(streamRate),
        .channelStatusBit1(channelStatusBit1), .burstValid(burstValid),
        .burstTypeIn(burstTypeIn), .burstLengthIn(burstLengthIn),
        .oscillatorAutoRequest(oscillatorAutoRequest),
        .internalConverterData(internalConverterData),
        .externalConverterData(externalConverterData), .rateTargetSelect(rateTargetSelect),
        .burstUpdatePulse(burstUpdatePulse), .controlDefaultPulse(controlDefaultPulse),
        .converterResetPulse(converterResetPulse), .converterPowerDown(converterPowerDown),
        .receiverPowerDown(receiverPowerDown), .transmitterPowerDown(transmitterPowerDown),
        .oscillatorRun(oscillatorRun), .converterClockOutEnable(converterClockOutEnable),
        .mainDataOut(mainDataOut), .converterClockSource(converterClockSource));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (burstUpdatePulse === 1'b1) updCnt++;
        if (controlDefaultPulse === 1'b1) defCnt++;
        if (converterResetPulse === 1'b1) rstCnt++;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), {8'h00, d & m}, {8'h00, e});
    endtask : rc

    task automatic wo(input logic [7:0] a, input logic [7:0] v);
        u_host.wr(a, v);
        cyc(2);
    endtask : wo

    task automatic stop_test();
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Far longer than the sequence below needs, which is under two thousand cycles.
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        int r, b, pr, sr, c;
        rst_b = 1'b0;
        portCalcBusy = 1'b1;
        portCalcRate = 4'h0;
        streamCalcBusy = 1'b1;
        streamLocked = 1'b0;
        streamRate = 4'h0;
        channelStatusBit1 = 1'b0;
        burstValid = 1'b0;
        burstTypeIn = 16'h0000;
        burstLengthIn = 16'h0000;
        oscillatorAutoRequest = 1'b1;
        internalConverterData = 1'b0;
        externalConverterData = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        rc(8'h37, 8'hff, 8'h00);
        rc(8'h40, 8'hff, 8'hc0);
        rc(8'h42, 8'hff, 8'h02);
        chk("clock source", 16'(converterClockSource), 16'h0002);
        chk("clock out enable", 16'(converterClockOutEnable), 16'h0001);
        pr = 0;
        for (int t = 0; t < 8; t++) begin
            u_host.wr(8'h37, 8'hf8 | 8'(t));
            rc(8'h37, 8'hff, 8'(t));
            chk("target", 16'(rateTargetSelect), 16'(t));
            r = int'(rnd() % 16);
            portCalcBusy = 1'b1;
            portCalcRate = 4'(r);
            cyc(3);
            rc(8'h38, 8'h8f, 8'h80 | 8'(pr));
            portCalcBusy = 1'b0;
            cyc(3);
            rc(8'h38, 8'hff, {1'b0, 3'(t), 4'(r)});
            rc(8'h38, 8'hff, {1'b0, 3'(t), 4'(r)});
            pr = r;
        end
        sr = 0;
        for (int i = 0; i < 4; i++) begin
            r = int'(rnd() % 16);
            streamCalcBusy = (i == 1);
            streamLocked = (i != 2);
            streamRate = 4'(r);
            channelStatusBit1 = i[0];
            cyc(4);
            b = int'(i == 1 || i == 2);
            if (b == 0) sr = r;
            rc(8'h39, 8'hff, {1'(b), i[0], 2'b00, 4'(sr)});
        end
        wo(8'h40, 8'hd0);
        chk("receiver down", 16'(receiverPowerDown), 16'h0001);
        streamRate = ~4'(sr);
        portCalcRate = ~4'(pr);
        cyc(4);
        rc(8'h39, 8'h8f, 8'h80 | 8'(sr));
        rc(8'h38, 8'h8f, 8'h80 | 8'(pr));
        wo(8'h40, 8'hc0);
        burstTypeIn = 16'(rnd()) | 16'h0001;
        burstLengthIn = 16'(rnd());
        burstValid = 1'b1;
        cyc(1);
        burstValid = 1'b0;
        cyc(3);
        chk("update pulses", 16'(updCnt), 16'h0001);
        // The captured words are read only after the update has been flagged.
        rc(8'h3a, 8'hff, burstTypeIn[7:0]);
        rc(8'h3b, 8'hff, burstTypeIn[15:8]);
        rc(8'h3c, 8'hff, burstLengthIn[7:0]);
        rc(8'h3d, 8'hff, burstLengthIn[15:8]);
        u_host.wr(8'h3b, ~burstTypeIn[15:8]);
        rc(8'h3b, 8'hff, burstTypeIn[15:8]);
        burstValid = 1'b1;
        cyc(1);
        burstValid = 1'b0;
        cyc(3);
        chk("update pulses", 16'(updCnt), 16'h0001);
        wo(8'h42, 8'hff);
        rc(8'h42, 8'hff, 8'h3f);
        u_host.wr(8'h37, 8'h05);
        wo(8'h40, 8'h40);
        chk("default pulses", 16'(defCnt), 16'h0001);
        rc(8'h40, 8'hff, 8'hc0);
        rc(8'h42, 8'hff, 8'h02);
        rc(8'h37, 8'hff, 8'h00);
        c = rstCnt;
        wo(8'h40, 8'h80);
        chk("converter reset pulses", 16'(rstCnt - c), 16'h0001);
        rc(8'h40, 8'hff, 8'hc0);
        rc(8'h41, 8'hff, 8'h00);
        rc(8'h3e, 8'hff, 8'h00);
        // All 16 patterns of the four power-down bits reach the power-down outputs; oscillator power-down wins.
        for (int m = 0; m < 16; m++) begin
            oscillatorAutoRequest = 1'(rnd());
            wo(8'h40, {2'b11, m[3], m[2], 2'b00, m[1], m[0]});
            chk("power down", 16'({converterPowerDown, receiverPowerDown,
                transmitterPowerDown}), 16'(m[3:1]));
            chk("oscillator", 16'(oscillatorRun), 16'(!m[0] && oscillatorAutoRequest));
        end
        wo(8'h40, 8'he0);
        chk("clock out enable", 16'(converterClockOutEnable), 16'h0001);
        wo(8'h42, 8'h22);
        chk("clock out enable", 16'(converterClockOutEnable), 16'h0000);
        wo(8'h40, 8'hc0);
        for (int s = 0; s < 6; s++) begin
            wo(8'h42, 8'(s));
            chk("clock source", 16'(converterClockSource), 16'(s));
        end
        for (int k = 0; k < 8; k++) begin
            internalConverterData = 1'(rnd());
            externalConverterData = 1'(rnd() >> 3);
            wo(8'h42, {3'b000, k[0], 4'h2});
            cyc(2);
            chk("main data", 16'(mainDataOut),
                16'(k[0] ? externalConverterData : internalConverterData));
        end
        streamCalcBusy = 1'b0;
        streamLocked = 1'b1;
        wo(8'h42, 8'h09);
        for (int q = 0; q < 4; q++) begin
            streamRate = 4'(lim[q]);
            cyc(5);
            chk("limiter", 16'(converterPowerDown), 16'(lim[q] >= 4 && lim[q] <= 12));
        end
        streamRate = 4'h8;
        wo(8'h42, 8'h0a);
        cyc(3);
        chk("limiter", 16'(converterPowerDown), 16'h0000);
        stop_test();
    end
endmodule : audio_rate_monitor_and_power_control_tb
